// [design/ptf_token_framer.sv]
// Behaviour
// - write to 43h pushes transmit queue
// - read of 43h pops receive queue
// - one token at a time, finished first
// - start pattern starts transmitter, not stored
// - sync tokens emit sync symbols
// - reset tokens emit reset symbols
// - top bits 100 mark payload header
// - low five bits count payload bytes
// - low nibble first, each 4b5b encoded
// - crc token inserts computed crc
// - eop token emits end symbol
// - off token switches driver off
// - tokens decoded by table, not line codes
// - receive packet starts with type marker
// - receive queue holds 80 bytes
`timescale 1ns/1ps
`default_nettype none
`include "ptf_defs.svh"
module ptf_token_framer (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire ptf_pkg::ptf_req_t REG_REQ,
	output logic [7:0] REG_RDATA,
	input wire logic TX_START,
	input wire ptf_pkg::ptf_rx_t RX_IN,
	input wire logic TX_SYM_READY,
	output ptf_pkg::ptf_sym_t TX_SYM,
	output logic TX_DRV_EN,
	output logic TX_RUN,
	output logic TX_FULL,
	output logic TX_EMPTY,
	output logic RX_FULL,
	output logic RX_EMPTY
);
	// ***********************************
	// register port decode
	// ***********************************
	logic wr_hit;
	logic rd_hit;
	logic transmit_on_command_hit;
	logic q_in_valid;
	logic q_in_ready;
	logic q_out_valid;
	logic [7:0] q_out_data;
	logic q_pop;
	logic [3:0] q_cnt;

	// queue address decode
	always_comb
	begin
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		if (REG_REQ.addr == `PTF_ADDR_QUEUE)
		begin
			wr_hit = REG_REQ.wr;
			rd_hit = REG_REQ.rd;
		end
	end

	// start pattern is a command, never a token
	assign transmit_on_command_hit = wr_hit &&
		((REG_REQ.wdata & `PTF_TRANSMIT_ON_COMMAND_MASK) == `PTF_TRANSMIT_ON_COMMAND_VAL);
	assign q_in_valid = wr_hit && !transmit_on_command_hit;

	// transmit queue, drops writes when full
	ptf_fifo #(
		.W(8),
		.D(`PTF_TX_DEPTH)
	) u_txq (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.in_valid(q_in_valid),
		.in_data(REG_REQ.wdata),
		.in_ready(q_in_ready),
		.out_valid(q_out_valid),
		.out_data(q_out_data),
		.out_ready(q_pop),
		.count(q_cnt)
	);

	// ***********************************
	// transmit token engine
	// ***********************************
	ptf_pkg::ptf_state_t state_q;
	ptf_pkg::ptf_state_t state_d;
	ptf_pkg::ptf_state_t ret_q;
	ptf_pkg::ptf_state_t ret_d;
	logic [7:0] tok_q;
	logic [4:0] tok_len;
	logic [7:0] byte_q;
	logic [4:0] pay_cnt_q;
	logic [31:0] crc_q;
	logic [31:0] crc_out_q;
	logic [3:0] nib_q;
	logic run_q;
	logic emit;
	logic [4:0] code;
	logic crc_clr;
	logic drv_off;
	logic pay_ld;
	logic nib_ld;
	logic nib_dec;
	logic pay_dec;

	assign tok_len = tok_q[4:0];

	// next state and per-token actions
	always_comb
	begin
		state_d = state_q;
		ret_d = ret_q;
		q_pop = 1'b0;
		emit = 1'b0;
		code = 5'h00;
		crc_clr = 1'b0;
		drv_off = 1'b0;
		pay_ld = 1'b0;
		nib_ld = 1'b0;
		nib_dec = 1'b0;
		pay_dec = 1'b0;
		case (state_q)
			ptf_pkg::S_IDLE:
			begin
				if (run_q && q_out_valid)
				begin
					q_pop = 1'b1;
					state_d = ptf_pkg::S_DECODE;
				end
			end
			ptf_pkg::S_DECODE:
			begin
				state_d = ptf_pkg::S_IDLE;
				if (tok_q == `PTF_TOK_SYNC1)
				begin
					emit = 1'b1;
					code = `PTF_K_SYNC1;
					crc_clr = 1'b1;
				end
				else if (tok_q == `PTF_TOK_SYNC2)
				begin
					emit = 1'b1;
					code = `PTF_K_SYNC2;
					crc_clr = 1'b1;
				end
				else if (tok_q == `PTF_TOK_SYNC3)
				begin
					emit = 1'b1;
					code = `PTF_K_SYNC3;
					crc_clr = 1'b1;
				end
				else if (tok_q == `PTF_TOK_RST1)
				begin
					emit = 1'b1;
					code = `PTF_K_RST1;
				end
				else if (tok_q == `PTF_TOK_RST2)
				begin
					emit = 1'b1;
					code = `PTF_K_RST2;
				end
				else if (tok_q == `PTF_TOK_EOP)
				begin
					emit = 1'b1;
					code = `PTF_K_EOP;
				end
				else if (tok_q == `PTF_TOK_CRC)
				begin
					nib_ld = 1'b1;
					state_d = ptf_pkg::S_CRC;
				end
				else if (tok_q == `PTF_TOK_OFF)
					drv_off = 1'b1;
				else if (tok_q[7:5] == `PTF_PACK_TOP &&
					tok_len != 5'h00)
				begin
					pay_ld = 1'b1;
					state_d = ptf_pkg::S_PAYW;
				end
				if (emit)
				begin
					ret_d = ptf_pkg::S_IDLE;
					state_d = ptf_pkg::S_SEND;
				end
			end
			ptf_pkg::S_SEND:
			begin
				if (TX_SYM_READY)
					state_d = ret_q;
			end
			ptf_pkg::S_PAYW:
			begin
				if (q_out_valid)
				begin
					q_pop = 1'b1;
					emit = 1'b1;
					code = ptf_pkg::enc(q_out_data[3:0]);
					ret_d = ptf_pkg::S_PAYH;
					state_d = ptf_pkg::S_SEND;
				end
			end
			ptf_pkg::S_PAYH:
			begin
				emit = 1'b1;
				code = ptf_pkg::enc(byte_q[7:4]);
				pay_dec = 1'b1;
				ret_d = (pay_cnt_q == 5'h01) ? ptf_pkg::S_IDLE :
					ptf_pkg::S_PAYW;
				state_d = ptf_pkg::S_SEND;
			end
			ptf_pkg::S_CRC:
			begin
				emit = 1'b1;
				code = ptf_pkg::enc(crc_out_q[3:0]);
				nib_dec = 1'b1;
				ret_d = (nib_q == 4'h1) ? ptf_pkg::S_IDLE :
					ptf_pkg::S_CRC;
				state_d = ptf_pkg::S_SEND;
			end
			default:
				state_d = ptf_pkg::S_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_q <= ptf_pkg::S_IDLE;
			ret_q <= ptf_pkg::S_IDLE;
		end
		else
		begin
			state_q <= state_d;
			ret_q <= ret_d;
		end
	end

	// token and payload byte capture
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			tok_q <= `PTF_QUEUE_RST;
			byte_q <= 8'h00;
		end
		else if (q_pop)
		begin
			if (state_q == ptf_pkg::S_IDLE)
				tok_q <= q_out_data;
			else
				byte_q <= q_out_data;
		end
	end

	// payload byte counter
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			pay_cnt_q <= 5'h00;
		else if (pay_ld)
			pay_cnt_q <= tok_len;
		else if (pay_dec)
			pay_cnt_q <= pay_cnt_q - 5'h01;
	end

	// running crc over payload, restarted by sync
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			crc_q <= `PTF_CRC_INIT;
		else if (crc_clr)
			crc_q <= `PTF_CRC_INIT;
		else if (state_q == ptf_pkg::S_PAYW && q_pop)
			crc_q <= ptf_pkg::crc_byte(crc_q, q_out_data);
	end

	// crc shifter, low nibble out first
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			crc_out_q <= 32'h0;
			nib_q <= 4'h0;
		end
		else if (nib_ld)
		begin
			crc_out_q <= ~crc_q;
			nib_q <= `PTF_CRC_NIBS;
		end
		else if (nib_dec)
		begin
			crc_out_q <= crc_out_q >> 4;
			nib_q <= nib_q - 4'h1;
		end
	end

	// transmitter run flag, a start beats a stop
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			run_q <= 1'b0;
		else if (transmit_on_command_hit || TX_START)
			run_q <= 1'b1;
		else if (drv_off)
			run_q <= 1'b0;
	end

	// symbol output, held until accepted
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			TX_SYM <= '0;
		else if (emit)
			TX_SYM <= '{valid: 1'b1, code: code};
		else if (TX_SYM_READY)
			TX_SYM.valid <= 1'b0;
	end

	// line driver enable
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			TX_DRV_EN <= 1'b0;
		else if (emit)
			TX_DRV_EN <= 1'b1;
		else if (drv_off)
			TX_DRV_EN <= 1'b0;
	end

	// ***********************************
	// receive queue
	// ***********************************
	logic [7:0] rx_mem [80];
	logic [6:0] rx_wp_q;
	logic [6:0] rx_rp_q;
	logic [6:0] rx_cnt_q;
	logic [7:0] rx_byte;
	logic [7:0] rx_head;
	logic rx_push;
	logic rx_pop;

	function automatic logic [6:0] rx_inc(input logic [6:0] p);
		return (p == `PTF_RX_LAST) ? 7'h00 : p + 7'h01;
	endfunction

	// marker first, then packet bytes
	always_comb
	begin
		rx_byte = RX_IN.data;
		if (RX_IN.sop)
		begin
			if (RX_IN.kind == 2'h1)
				rx_byte = {`PTF_MARK_SYNC_ONE_TOKEN, 5'h00};
			else if (RX_IN.kind == 2'h2)
				rx_byte = {`PTF_MARK_SYNC_TWO_TOKEN, 5'h00};
			else
				rx_byte = {`PTF_MARK_SOP, 5'h00};
		end
	end

	assign rx_push = (RX_IN.sop || RX_IN.dv) &&
		rx_cnt_q != `PTF_RX_DEPTH;
	assign rx_pop = rd_hit && rx_cnt_q != 7'h00;
	assign rx_head = rx_mem[rx_rp_q];

	// receive storage
	always_ff @(posedge CORE_CLK)
	begin
		if (rx_push)
			rx_mem[rx_wp_q] <= rx_byte;
	end

	// receive pointers and fill
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rx_wp_q <= 7'h00;
			rx_rp_q <= 7'h00;
			rx_cnt_q <= 7'h00;
		end
		else
		begin
			if (rx_push)
				rx_wp_q <= rx_inc(rx_wp_q);
			if (rx_pop)
				rx_rp_q <= rx_inc(rx_rp_q);
			rx_cnt_q <= rx_cnt_q + {6'h00, rx_push} - {6'h00, rx_pop};
		end
	end

	// read data, zero when empty
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
			REG_RDATA <= `PTF_QUEUE_RST;
		else if (rx_pop)
			REG_RDATA <= rx_head;
		else if (REG_REQ.rd)
			REG_RDATA <= 8'h00;
	end

	// status flags
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			TX_RUN <= 1'b0;
			TX_FULL <= 1'b0;
			TX_EMPTY <= 1'b1;
			RX_FULL <= 1'b0;
			RX_EMPTY <= 1'b1;
		end
		else
		begin
			TX_RUN <= run_q;
			TX_FULL <= !q_in_ready;
			TX_EMPTY <= !q_out_valid;
			RX_FULL <= rx_cnt_q == `PTF_RX_DEPTH;
			RX_EMPTY <= rx_cnt_q == 7'h00;
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);

	sequence s_decode_sym;
		state_q == ptf_pkg::S_DECODE && TX_SYM_READY == 1'b0 ##1
		state_q == ptf_pkg::S_SEND;
	endsequence
	sequence s_byte_take;
		state_q == ptf_pkg::S_PAYW && q_pop;
	endsequence

	a_transmit_on_command_no_store: assert property (transmit_on_command_hit |=>
		run_q && q_cnt == $past(q_cnt) - 4'($past(q_pop)))
		else $error("start pattern entered the queue");
	a_queue_push: assert property (q_in_valid && q_in_ready &&
		!q_pop |=> q_cnt == $past(q_cnt) + 4'h1)
		else $error("queue write not stored");
	a_full_drop: assert property (q_in_valid && !q_in_ready &&
		!q_pop |=> q_cnt == $past(q_cnt))
		else $error("write to full queue changed it");
	a_rx_read_pop: assert property (rx_pop && !rx_push |=>
		REG_RDATA == $past(rx_head) &&
		rx_cnt_q == $past(rx_cnt_q) - 7'h01)
		else $error("receive read did not pop head");
	a_rx_empty_read: assert property (rd_hit &&
		rx_cnt_q == 7'h00 |=> REG_RDATA == 8'h00 && $stable(rx_rp_q))
		else $error("empty read not zero");
	a_rx_marker: assert property (RX_IN.sop && rx_push &&
		RX_IN.kind == 2'h1 |=>
		rx_mem[$past(rx_wp_q)][7:5] == `PTF_MARK_SYNC_ONE_TOKEN)
		else $error("receive marker wrong");
	a_rx_depth: assert property (rx_cnt_q <= `PTF_RX_DEPTH)
		else $error("receive queue over depth");
	a_one_token: assert property (s_decode_sym |-> !q_pop)
		else $error("token fetched before symbol done");
	a_sync_one: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_SYNC1 |=>
		TX_SYM.valid && TX_SYM.code == `PTF_K_SYNC1)
		else $error("sync one symbol wrong");
	a_sync_three: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_SYNC3 |=> TX_SYM.code == `PTF_K_SYNC3)
		else $error("sync three symbol wrong");
	a_reset_two: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_RST2 |=> TX_SYM.code == `PTF_K_RST2)
		else $error("reset symbol wrong");
	a_pack_load: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q[7:5] == `PTF_PACK_TOP && tok_len != 5'h00 |=>
		state_q == ptf_pkg::S_PAYW && pay_cnt_q == $past(tok_len))
		else $error("payload header not loaded");
	a_nibble_order: assert property (s_byte_take |=>
		TX_SYM.code == ptf_pkg::enc(byte_q[3:0]) &&
		ret_q == ptf_pkg::S_PAYH)
		else $error("low nibble not first");
	a_crc_start: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_CRC |=> state_q == ptf_pkg::S_CRC &&
		nib_q == `PTF_CRC_NIBS && crc_out_q == ~$past(crc_q))
		else $error("crc insert not started");
	a_eop_symbol: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_EOP |=> TX_SYM.code == `PTF_K_EOP)
		else $error("eop symbol wrong");
	a_driver_off: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == `PTF_TOK_OFF && !TX_START && !transmit_on_command_hit |=>
		!TX_DRV_EN && !run_q)
		else $error("driver not switched off");
	a_unknown_drop: assert property (state_q == ptf_pkg::S_DECODE &&
		tok_q == 8'h18 |=> state_q == ptf_pkg::S_IDLE &&
		!TX_SYM.valid && TX_DRV_EN == $past(TX_DRV_EN))
		else $error("unknown token not discarded");
endmodule
`default_nettype wire

// [inc/ptf_defs.svh]
`ifndef PTF_DEFS_SVH
`define PTF_DEFS_SVH
// register offset and reset value
`define PTF_ADDR_QUEUE 8'h43
`define PTF_QUEUE_RST 8'h00
// start command pattern 101x_xxx1
`define PTF_TRANSMIT_ON_COMMAND_MASK 8'he1
`define PTF_TRANSMIT_ON_COMMAND_VAL 8'ha1
// transmit token codes
`define PTF_TOK_SYNC1 8'h12
`define PTF_TOK_SYNC2 8'h13
`define PTF_TOK_SYNC3 8'h1b
`define PTF_TOK_RST1 8'h15
`define PTF_TOK_RST2 8'h16
`define PTF_TOK_EOP 8'h14
`define PTF_TOK_CRC 8'hff
`define PTF_TOK_OFF 8'hfe
`define PTF_PACK_TOP 3'h4
// line symbols
`define PTF_K_SYNC1 5'h18
`define PTF_K_SYNC2 5'h11
`define PTF_K_SYNC3 5'h06
`define PTF_K_RST1 5'h07
`define PTF_K_RST2 5'h19
`define PTF_K_EOP 5'h0d
// receive markers and depths
`define PTF_MARK_SOP 3'h7
`define PTF_MARK_SYNC_ONE_TOKEN 3'h6
`define PTF_MARK_SYNC_TWO_TOKEN 3'h5
`define PTF_RX_DEPTH 7'h50
`define PTF_RX_LAST 7'h4f
`define PTF_TX_DEPTH 8
// crc
`define PTF_CRC_INIT 32'hffffffff
`define PTF_CRC_POLY 32'hedb88320
`define PTF_CRC_NIBS 4'h8
`endif

// [inc/ptf_pkg.sv]
`include "ptf_defs.svh"
package ptf_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DECODE = 3'b001,
		S_SEND = 3'b010,
		S_PAYW = 3'b011,
		S_PAYH = 3'b100,
		S_CRC = 3'b101
	} ptf_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ptf_req_t;
	typedef struct packed {
		logic sop;
		logic [1:0] kind;
		logic dv;
		logic [7:0] data;
	} ptf_rx_t;
	typedef struct packed {
		logic valid;
		logic [4:0] code;
	} ptf_sym_t;
	// 4b5b data encoding
	function automatic logic [4:0] enc(input logic [3:0] n);
		logic [4:0] t [16];
		t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
			5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
		return t[n];
	endfunction
	// reflected crc update, lsb first
	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r >> 1) ^ ((r[0] ^ b[i]) ? `PTF_CRC_POLY : 32'h0);
		return r;
	endfunction
endpackage

// [design/ptf_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ptf_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(D+1)-1:0] count
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D+1);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	// handshake terms
	assign in_ready = cnt_q != CW'(D);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];
	assign count = cnt_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_q] <= in_data;
	end

	// pointers with wrap
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
		end
	end

	// fill level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
	end
endmodule
`default_nettype wire

// [verif/ptf_sym_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// line symbol sink model
// ****************************************
module ptf_sym_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic ready
);
	integer seed = 7;
	// accept at once, or stall at random when slow
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ready <= 1'b0;
		else
			ready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
	end
endmodule
`default_nettype wire

// [verif/tb_ptf_token_framer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptf_defs.svh"
module tb_ptf_token_framer;
	// ****************************************
	// signals and scoreboard
	// ****************************************
	logic core_clk;
	logic rstn;
	ptf_pkg::ptf_req_t req;
	logic [7:0] reg_rdata;
	logic tx_start;
	ptf_pkg::ptf_rx_t rx_in;
	logic sym_ready;
	ptf_pkg::ptf_sym_t sym;
	logic tx_drv_en;
	logic tx_run;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic slow;
	integer seed = 82;
	int mismatches = 0;
	int n_compared = 0;
	logic [4:0] exp_sym [$];
	logic [7:0] exp_rd [$];
	event rd_ev;
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
		5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
		5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic [7:0] toks [8] = '{`PTF_TOK_SYNC1, `PTF_TOK_SYNC2,
		`PTF_TOK_SYNC3, `PTF_TOK_RST1, `PTF_TOK_RST2, 8'h18,
		`PTF_TOK_EOP, `PTF_TOK_OFF};
	logic [4:0] ks [6] = '{`PTF_K_SYNC1, `PTF_K_SYNC2, `PTF_K_SYNC3,
		`PTF_K_RST1, `PTF_K_RST2, `PTF_K_EOP};

	// design and symbol sink
	ptf_token_framer u_ptf_token_framer (
		.CORE_CLK(core_clk),
		.RSTN(rstn),
		.REG_REQ(req),
		.REG_RDATA(reg_rdata),
		.TX_START(tx_start),
		.RX_IN(rx_in),
		.TX_SYM_READY(sym_ready),
		.TX_SYM(sym),
		.TX_DRV_EN(tx_drv_en),
		.TX_RUN(tx_run),
		.TX_FULL(tx_full),
		.TX_EMPTY(tx_empty),
		.RX_FULL(rx_full),
		.RX_EMPTY(rx_empty)
	);
	ptf_sym_sink u_ptf_sym_sink (
		.clk(core_clk),
		.rst_n(rstn),
		.slow(slow),
		.ready(sym_ready)
	);

	// ****************************************
	// compare and report tasks
	// ****************************************
	task automatic fail(input string msg);
		mismatches++;
		$display("[ERR] %0t %s", $time, msg);
	endtask
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
			fail($sformatf("read %h expected %h", g, e));
	endtask
	task automatic cmp_sym(input logic [4:0] g, input logic [4:0] e);
		n_compared++;
		if (g !== e)
			fail($sformatf("symbol %h expected %h", g, e));
	endtask
	task automatic cmp1(input logic g, input logic e, input string nm);
		n_compared++;
		if (g !== e)
			fail($sformatf("%s is %b", nm, g));
	endtask
	task give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// drivers
	// ****************************************
	task automatic wr(input logic [7:0] b, input bit safe);
		if (safe)
		begin
			@(negedge core_clk);
			while (tx_full !== 1'b0)
				@(negedge core_clk);
		end
		@(posedge core_clk);
		req <= '{wr:1'b1, rd:1'b0, addr:`PTF_ADDR_QUEUE, wdata:b};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd();
		@(posedge core_clk);
		req <= '{wr:1'b0, rd:1'b1, addr:`PTF_ADDR_QUEUE, wdata:8'h00};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
		@(negedge core_clk);
		->rd_ev;
	endtask
	task automatic rxp(input logic s, input logic [1:0] k, input logic d,
		input logic [7:0] b);
		@(posedge core_clk);
		rx_in <= '{sop:s, kind:k, dv:d, data:b};
		@(posedge core_clk);
		rx_in <= '0;
	endtask
	task automatic pulse_start();
		@(posedge core_clk);
		tx_start <= 1'b1;
		@(posedge core_clk);
		tx_start <= 1'b0;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		@(negedge core_clk);
		while ((tx_run !== 1'b0 || exp_sym.size() != 0) && k < 4000)
		begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 4000)
			fail("transmitter never went idle");
		repeat (2) @(negedge core_clk);
		cmp1(tx_drv_en, 1'b0, "driver enable");
		cmp1(tx_empty, 1'b1, "tx empty");
	endtask
	function automatic logic [31:0] crc_upd(input logic [31:0] c,
		input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ `PTF_CRC_POLY) : (c >> 1);
		return c;
	endfunction
	// sync, packed payload, crc, eop, off
	task automatic send_pkt(input int n, input bit start_first);
		logic [31:0] c;
		logic [7:0] b;
		c = `PTF_CRC_INIT;
		if (start_first)
			pulse_start();
		exp_sym.push_back(`PTF_K_SYNC1);
		wr(`PTF_TOK_SYNC1, 1);
		wr({`PTF_PACK_TOP, 5'(n)}, 1);
		for (int i = 0; i < n; i++)
		begin
			b = 8'($random(seed));
			// a data byte never looks like the start command
			if ((b & `PTF_TRANSMIT_ON_COMMAND_MASK) == `PTF_TRANSMIT_ON_COMMAND_VAL)
				b[0] = 1'b0;
			exp_sym.push_back(ENC[b[3:0]]);
			exp_sym.push_back(ENC[b[7:4]]);
			c = crc_upd(c, b);
			wr(b, 1);
		end
		c = ~c;
		for (int i = 0; i < 8; i++)
			exp_sym.push_back(ENC[c[4*i+:4]]);
		wr(`PTF_TOK_CRC, 1);
		exp_sym.push_back(`PTF_K_EOP);
		wr(`PTF_TOK_EOP, 1);
		wr(`PTF_TOK_OFF, 1);
		if (!start_first)
			pulse_start();
		wait_idle();
	endtask

	// ****************************************
	// monitors
	// ****************************************
	// accepted symbols against the oldest note
	always @(posedge core_clk)
	begin
		if (sym.valid === 1'b1 && sym_ready === 1'b1)
		begin
			cmp1(tx_drv_en, 1'b1, "driver enable");
			if (exp_sym.size() == 0)
				fail("unexpected symbol");
			else
				cmp_sym(sym.code, exp_sym.pop_front());
		end
	end
	// read data against the oldest note
	always @(rd_ev)
	begin
		if (exp_rd.size() == 0)
			fail("unexpected read");
		else
			cmp8(reg_rdata, exp_rd.pop_front());
	end

	// clock and watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail("watchdog expired");
		give_verdict();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		logic [7:0] b;
		rstn = 1'b0;
		req = '0;
		tx_start = 1'b0;
		rx_in = '0;
		slow = 1'b0;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		cmp8(reg_rdata, `PTF_QUEUE_RST);
		cmp1(tx_empty, 1'b1, "tx empty");
		cmp1(rx_empty, 1'b1, "rx empty");
		cmp1(sym.valid, 1'b0, "symbol valid");
		@(posedge core_clk);
		rstn <= 1'b1;
		// token table, unlisted line code, queue full, start pattern
		foreach (toks[i])
			wr(toks[i], 0);
		@(negedge core_clk);
		cmp1(tx_full, 1'b1, "tx full");
		wr(`PTF_TOK_SYNC1, 0);
		foreach (ks[i])
			exp_sym.push_back(ks[i]);
		wr(`PTF_TRANSMIT_ON_COMMAND_VAL, 0);
		@(negedge core_clk);
		cmp1(tx_run, 1'b1, "tx run");
		wait_idle();
		// packed payloads, short loaded then long streamed with stalls
		send_pkt(2, 0);
		slow = 1'b1;
		send_pkt(30, 1);
		// receive markers, fill to capacity, drain past empty
		for (int k = 0; k < 3; k++)
		begin
			exp_rd.push_back({3'(7 - k), 5'h00});
			rxp(1'b1, 2'(k), 1'b0, 8'h00);
		end
		for (int k = 0; k < 78; k++)
		begin
			b = 8'($random(seed));
			if (k < 77)
				exp_rd.push_back(b);
			rxp(1'b0, 2'h0, 1'b1, b);
		end
		@(posedge core_clk);
		@(negedge core_clk);
		cmp1(rx_full, 1'b1, "rx full");
		exp_rd.push_back(8'h00);
		repeat (81) rd();
		repeat (2) @(negedge core_clk);
		cmp1(rx_empty, 1'b1, "rx empty");
		give_verdict();
	end
endmodule
`default_nettype wire
